// ---- hdl/aer_status_pkg.sv ----
// Package: register map, field positions and carriers for the error status bank
package aer_status_pkg;
   localparam logic [11:0] capability_header_offset = 12'h100;
   localparam logic [11:0] uncorrectable_status_offset = 12'h104;
   localparam logic [11:0] header_lock_offset = 12'h180;
   localparam logic [15:0] capability_identifier = 16'h0001;
   localparam logic [3:0] capability_version = 4'h1;
   localparam logic [11:0] next_offset_reset = 12'h000;
   localparam int next_offset_lsb = 20;
   localparam int header_lock_bit = 0;
   localparam logic [31:0] status_reset = 32'h0000_0000;
   // Bits that software clears with a one; hardware sets all of them except bit zero
   localparam logic [31:0] status_settable_mask = 32'h00ff_3031;
   localparam int unused_legacy_bit = 0;
   localparam int link_layer_protocol_fault = 4;
   localparam int surprise_link_down_fault = 5;
   localparam int poisoned_packet_flag = 12;
   localparam int credit_protocol_fault = 13;
   localparam int completion_timeout_flag = 14;
   localparam int completer_abort_flag = 15;
   localparam int unmatched_completion_flag = 16;
   localparam int receive_overflow_flag = 17;
   localparam int malformed_packet_flag = 18;
   localparam int end_to_end_crc_flag = 19;
   localparam int unsupported_request_flag = 20;
   localparam int access_control_violation_flag = 21;
   localparam int internal_fault_flag = 22;
   localparam int multicast_drop_flag = 23;

   typedef struct packed {
      logic link_protocol;
      logic surprise_down;
      logic poisoned;
      logic credit_protocol;
      logic unmatched_completion;
      logic receive_overflow;
      logic malformed;
      logic crc;
      logic unsupported;
      logic access_violation;
      logic internal_fault;
      logic multicast_drop;
   } error_events_type;
endpackage

// ---- hdl/aer_uncorrectable_status.sv ----
// Error reporting capability header and uncorrectable status over APB
//
// Notes on behaviour
// [R01] Header low half reads capability identifier one
// [R02] Header bits 19:16 read version one
// [R03] Next capability offset in bits 31:20
// [R04] Bit zero sticky write-one-clear, never set
// [R05] Bit four sets on link protocol fault
// [R06] Bit five sets on surprise down if capable
// [R07] Bit twelve sets on poisoned packet
// [R08] Bit thirteen sets on credit protocol fault
// [R09] Completion timeout bit fourteen reads zero
// [R10] Completer abort bit fifteen never sets
// [R11] Bit sixteen sets on unmatched completion
// [R12] Bit seventeen sets on receive overflow
// [R13] Bit eighteen sets on malformed packet
// [R14] Bit nineteen sets on end-to-end CRC failure
// [R15] Bit twenty sets on unsupported request
// [R16] Bit twenty-one sets on access violation
// [R17] Bit twenty-two sets on internal fault
// [R18] Bit twenty-three sets on multicast drop
// [R19] Write one clears; survives non-fundamental reset
// [R20] Reserved bits read zero, ignore writes
// [R21] Masking never stops status bits setting
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module aer_uncorrectable_status (
   input  wire logic                             pclk,          // 20 MHz
   input  wire logic                             presetn,       // Fundamental
   input  wire logic                             psel,          // APB select
   input  wire logic                             penable,       // APB enable
   input  wire logic                             pwrite,        // APB write
   input  wire logic [11:0]                      paddr,         // Byte addr
   input  wire logic [31:0]                      pwdata,        // Write data
   output logic      [31:0]                      prdata,        // Read data
   output logic                                  pready,        // Always ready
   output logic                                  pslverr,       // Unmapped
   input  wire logic                             hot_reset,     // Non-fundam.
   input  wire aer_status_pkg::error_events_type error_events,  // Detectors
   input  wire logic                             surprise_down_reporting_capable, // Link cap
   input  wire logic [31:0]                      error_mask,    // Mask reg
   output logic                                  unmasked_error // To reporter
);
   import aer_status_pkg::*;

   logic [11:0] next_capability_offset;
   logic        header_locked;
   logic [31:0] uncorrectable_error_status;
   logic [31:0] set_vector;
   logic [31:0] clear_vector;
   logic [31:0] error_reporting_capability_header;
   logic        wr_access;
   logic        rd_access;
   logic        mapped;

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign mapped    = (paddr == capability_header_offset) ||
                      (paddr == uncorrectable_status_offset) ||
                      (paddr == header_lock_offset);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !mapped;

   assign error_reporting_capability_header =
      {next_capability_offset, capability_version,          // [R03] [R02]
       capability_identifier};                              // [R01]

   ////////////////////////////////////////////////////////////////////////
   // Next offset is writable until software locks it (write-lock field)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_capability_offset <= next_offset_reset;
      end else if (wr_access && !header_locked &&
                   paddr == capability_header_offset) begin
         next_capability_offset <=
            pwdata[next_offset_lsb +: $bits(next_capability_offset)]; // [R03]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         header_locked <= 1'b0;
      end else if (wr_access && paddr == header_lock_offset) begin
         header_locked <= pwdata[header_lock_bit];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status set and clear
   always_comb begin
      set_vector = '0;
      set_vector[unused_legacy_bit]          = 1'b0;               // [R04]
      set_vector[link_layer_protocol_fault]  =
         error_events.link_protocol;                                // [R05]
      set_vector[surprise_link_down_fault]   = error_events.surprise_down &&
                                   surprise_down_reporting_capable; // [R06]
      set_vector[poisoned_packet_flag]       = error_events.poisoned; // [R07]
      set_vector[credit_protocol_fault]      =
         error_events.credit_protocol;                              // [R08]
      set_vector[completion_timeout_flag]    = 1'b0;               // [R09]
      set_vector[completer_abort_flag]       = 1'b0;               // [R10]
      set_vector[unmatched_completion_flag]  =
         error_events.unmatched_completion;                         // [R11]
      set_vector[receive_overflow_flag]      =
         error_events.receive_overflow;                             // [R12]
      set_vector[malformed_packet_flag]      = error_events.malformed; // [R13]
      set_vector[end_to_end_crc_flag]        = error_events.crc;   // [R14]
      set_vector[unsupported_request_flag]   =
         error_events.unsupported;                                  // [R15]
      set_vector[access_control_violation_flag] =
         error_events.access_violation;                             // [R16]
      set_vector[internal_fault_flag]        =
         error_events.internal_fault;                               // [R17]
      set_vector[multicast_drop_flag]        =
         error_events.multicast_drop;                               // [R18]
   end

   assign clear_vector = (wr_access && paddr == uncorrectable_status_offset)
                         ? pwdata & status_settable_mask : '0;      // [R19]

   // Sticky: only the fundamental reset clears; hot_reset is ignored here.
   // The mask is not consulted, so masked errors still set status. A set
   // in the clearing cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uncorrectable_error_status <= status_reset;
      end else begin
         uncorrectable_error_status <= ((uncorrectable_error_status &
            ~clear_vector) | set_vector) &
            status_settable_mask;                      // [R19] [R20] [R21]
      end
   end

   // Mask only gates reporting
   assign unmasked_error =
      |(uncorrectable_error_status & ~error_mask);                  // [R21]

   ////////////////////////////////////////////////////////////////////////
   // Read data registered in the setup cycle, valid in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_access) begin
         case (paddr)
            capability_header_offset:
               prdata <= error_reporting_capability_header;
            uncorrectable_status_offset:
               prdata <= uncorrectable_error_status;               // [R20]
            header_lock_offset:
               prdata <= 32'(header_locked);
            default:
               prdata <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_sticky_hot;
      @(posedge pclk) disable iff (!presetn)
      hot_reset && !wr_access |=> uncorrectable_error_status ==
         ($past(uncorrectable_error_status) | $past(set_vector));
   endproperty
   a_sticky_hot: assert property (p_sticky_hot) // [R19]
      else $error("status changed on hot reset");

   property p_link;
      @(posedge pclk) disable iff (!presetn)
      error_events.link_protocol |=>
         uncorrectable_error_status[link_layer_protocol_fault];
   endproperty
   a_link: assert property (p_link) // [R05]
      else $error("link fault not captured");

   property p_sdown;
      @(posedge pclk) disable iff (!presetn)
      error_events.surprise_down && surprise_down_reporting_capable |=>
         uncorrectable_error_status[surprise_link_down_fault];
   endproperty
   a_sdown: assert property (p_sdown) // [R06]
      else $error("surprise down not captured");

   property p_sdown_gate;
      @(posedge pclk) disable iff (!presetn)
      !$past(uncorrectable_error_status[surprise_link_down_fault]) &&
      !$past(surprise_down_reporting_capable) |->
         !uncorrectable_error_status[surprise_link_down_fault];
   endproperty
   a_sdown_gate: assert property (p_sdown_gate) // [R06]
      else $error("surprise down set without capability");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
      (uncorrectable_error_status & ~status_settable_mask) == '0;
   endproperty
   a_reserved: assert property (p_reserved) // [R20]
      else $error("reserved status bit set");

   property p_fixed_zero;
      @(posedge pclk) disable iff (!presetn)
      !uncorrectable_error_status[completion_timeout_flag] &&
      !uncorrectable_error_status[completer_abort_flag] &&
      !uncorrectable_error_status[unused_legacy_bit];
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) // [R09] [R10] [R04]
      else $error("hardwired status bit set");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == uncorrectable_status_offset &&
      pwdata[receive_overflow_flag] && !error_events.receive_overflow |=>
         !uncorrectable_error_status[receive_overflow_flag];
   endproperty
   a_clear: assert property (p_clear) // [R19]
      else $error("write one did not clear");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      uncorrectable_error_status[malformed_packet_flag] &&
      !clear_vector[malformed_packet_flag] |=>
         uncorrectable_error_status[malformed_packet_flag];
   endproperty
   a_hold: assert property (p_hold) // [R13] [R19]
      else $error("status lost without clear");

   property p_header;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == capability_header_offset |=>
         prdata[next_offset_lsb-1:0] ==
            {capability_version, capability_identifier};
   endproperty
   a_header: assert property (p_header) // [R01] [R02]
      else $error("header identity wrong");

   property p_mask;
      @(posedge pclk) disable iff (!presetn)
      error_events.crc && error_mask[end_to_end_crc_flag] |=>
         uncorrectable_error_status[end_to_end_crc_flag];
   endproperty
   a_mask: assert property (p_mask) // [R21] [R14]
      else $error("mask blocked status");

   // One capture check per detector input
   property p_poisoned;
      @(posedge pclk) disable iff (!presetn)
      error_events.poisoned |=>
         uncorrectable_error_status[poisoned_packet_flag];
   endproperty
   a_poisoned: assert property (p_poisoned) // [R07]
      else $error("poisoned packet not captured");

   property p_credit;
      @(posedge pclk) disable iff (!presetn)
      error_events.credit_protocol |=>
         uncorrectable_error_status[credit_protocol_fault];
   endproperty
   a_credit: assert property (p_credit) // [R08]
      else $error("credit protocol fault not captured");

   property p_unmatched;
      @(posedge pclk) disable iff (!presetn)
      error_events.unmatched_completion |=>
         uncorrectable_error_status[unmatched_completion_flag];
   endproperty
   a_unmatched: assert property (p_unmatched) // [R11]
      else $error("unmatched completion not captured");

   property p_overflow;
      @(posedge pclk) disable iff (!presetn)
      error_events.receive_overflow |=>
         uncorrectable_error_status[receive_overflow_flag];
   endproperty
   a_overflow: assert property (p_overflow) // [R12]
      else $error("receive overflow not captured");

   property p_malformed;
      @(posedge pclk) disable iff (!presetn)
      error_events.malformed |=>
         uncorrectable_error_status[malformed_packet_flag];
   endproperty
   a_malformed: assert property (p_malformed) // [R13]
      else $error("malformed packet not captured");

   property p_crc;
      @(posedge pclk) disable iff (!presetn)
      error_events.crc |=>
         uncorrectable_error_status[end_to_end_crc_flag];
   endproperty
   a_crc: assert property (p_crc) // [R14]
      else $error("end-to-end check failure not captured");

   property p_unsupported;
      @(posedge pclk) disable iff (!presetn)
      error_events.unsupported |=>
         uncorrectable_error_status[unsupported_request_flag];
   endproperty
   a_unsupported: assert property (p_unsupported) // [R15]
      else $error("unsupported request not captured");

   property p_access;
      @(posedge pclk) disable iff (!presetn)
      error_events.access_violation |=>
         uncorrectable_error_status[access_control_violation_flag];
   endproperty
   a_access: assert property (p_access) // [R16]
      else $error("access violation not captured");

   property p_internal;
      @(posedge pclk) disable iff (!presetn)
      error_events.internal_fault |=>
         uncorrectable_error_status[internal_fault_flag];
   endproperty
   a_internal: assert property (p_internal) // [R17]
      else $error("internal fault not captured");

   property p_multicast;
      @(posedge pclk) disable iff (!presetn)
      error_events.multicast_drop |=>
         uncorrectable_error_status[multicast_drop_flag];
   endproperty
   a_multicast: assert property (p_multicast) // [R18]
      else $error("multicast drop not captured");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      |set_vector |=> (uncorrectable_error_status & $past(set_vector)) ==
         $past(set_vector);
   endproperty
   a_set_wins: assert property (p_set_wins) // [R19]
      else $error("detected error lost in the clearing cycle");

   property p_keep;
      @(posedge pclk) disable iff (!presetn)
      !(wr_access && paddr == uncorrectable_status_offset) |=>
         (uncorrectable_error_status & $past(uncorrectable_error_status)) ==
            $past(uncorrectable_error_status);
   endproperty
   a_keep: assert property (p_keep) // [R19]
      else $error("status bit fell without a clearing write");

   property p_clear_all;
      @(posedge pclk) disable iff (!presetn)
      wr_access && paddr == uncorrectable_status_offset |=>
         (uncorrectable_error_status & $past(pwdata) &
          status_settable_mask & ~$past(set_vector)) == '0;
   endproperty
   a_clear_all: assert property (p_clear_all) // [R19]
      else $error("written one left status bit set");

   property p_lock;
      @(posedge pclk) disable iff (!presetn)
      header_locked |=>
         next_capability_offset == $past(next_capability_offset);
   endproperty
   a_lock: assert property (p_lock) // [R03]
      else $error("locked next offset changed");

   property p_reserved_read;
      @(posedge pclk) disable iff (!presetn)
      rd_access && paddr == uncorrectable_status_offset |=>
         (prdata & ~status_settable_mask) == '0;
   endproperty
   a_reserved_read: assert property (p_reserved_read) // [R20]
      else $error("reserved status bit read as one");

   c_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
      clear_vector[unsupported_request_flag] &&
      error_events.unsupported);
   c_hot: cover property (@(posedge pclk) disable iff (!presetn)
      hot_reset && |uncorrectable_error_status);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pslverr);
   c_lock: cover property (@(posedge pclk) disable iff (!presetn)
      header_locked && wr_access && paddr == capability_header_offset);
   c_mask_crc: cover property (@(posedge pclk) disable iff (!presetn)
      error_events.crc && error_mask[end_to_end_crc_flag]);
endmodule

// ---- tb/error_source.sv ----
// Partner model: the port's error detectors, one-cycle event pulses
`timescale 1ns/1ps
module error_source (
   input  wire logic                             pclk,         // Port clock
   input  wire logic                             presetn,      // Reset
   input  wire logic [11:0]                      request,      // Bench order
   output aer_status_pkg::error_events_type      error_events  // To port
);
   import aer_status_pkg::*;
   // Registered so events launch just after an edge like real detectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_events <= '0;
      end else begin
         error_events <= request;
      end
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the error status bank over APB
`timescale 1ns/1ps
module testbench;
   import aer_status_pkg::*;
   logic             pclk = 1'b0;
   logic             presetn = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0000_0000;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             hot_reset = 1'b0;
   logic             capable = 1'b0;
   logic [31:0]      error_mask = 32'h0000_0000;
   logic             unmasked_error;
   logic [11:0]      request = 12'h000;
   error_events_type error_events;
   int               miscompares = 0;
   int               comparisons = 0;
   // Status bit for each event, struct msb first
   int bitpos [12] = '{link_layer_protocol_fault, surprise_link_down_fault,
      poisoned_packet_flag, credit_protocol_fault, unmatched_completion_flag,
      receive_overflow_flag, malformed_packet_flag, end_to_end_crc_flag,
      unsupported_request_flag, access_control_violation_flag,
      internal_fault_flag, multicast_drop_flag};
   always #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   aer_uncorrectable_status u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hot_reset(hot_reset), .error_events(error_events),
      .surprise_down_reporting_capable(capable), .error_mask(error_mask),
      .unmasked_error(unmasked_error));
   error_source u_source (.pclk(pclk), .presetn(presetn), .request(request),
      .error_events(error_events));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Idle edge first so a release never meets the next setup
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // No local limit: a stalled slave is ended by the watchdog alone
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk("wait states", 32'(n), 32'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("read data", r, exp);
   endtask
   task automatic fire(input logic [11:0] v);
      @(posedge pclk);
      request <= v;
      @(posedge pclk);
      request <= 12'h000;
   endtask
   // Set one detector, then show that only a written one clears it
   task automatic event_check(input int i);
      logic [31:0] exp;
      exp = 32'h1 << bitpos[i];
      fire(12'h800 >> i);
      rd(uncorrectable_status_offset, exp);
      wr(uncorrectable_status_offset, ~exp);
      rd(uncorrectable_status_offset, exp);
      wr(uncorrectable_status_offset, exp);
      rd(uncorrectable_status_offset, 32'h0000_0000);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      print_verdict;
   end
   initial begin
      logic [31:0] r;
      logic [31:0] exp;
      logic        e;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      exp = {next_offset_reset, capability_version, capability_identifier};
      rd(capability_header_offset, exp);
      rd(uncorrectable_status_offset, status_reset);
      event_check(0);
      // Surprise down is ignored until the link advertises it
      fire(12'h400);
      rd(uncorrectable_status_offset, 32'h0000_0000);
      capable <= 1'b1;
      event_check(1);
      event_check(2);
      event_check(3);
      event_check(4);
      event_check(5);
      event_check(6);
      event_check(7);
      event_check(8);
      event_check(9);
      event_check(10);
      event_check(11);
      wr(uncorrectable_status_offset, 32'hffff_ffff);
      rd(uncorrectable_status_offset, 32'h0000_0000);
      fire(12'hfff);
      exp = 32'h00ff_3030;
      rd(uncorrectable_status_offset, exp);
      error_mask <= 32'h0000_0000;
      repeat (2) @(posedge pclk);
      chk("unmasked error", {31'h0, unmasked_error}, 32'h1);
      error_mask <= 32'hffff_ffff;
      repeat (2) @(posedge pclk);
      chk("unmasked error", {31'h0, unmasked_error}, 32'h0);
      rd(uncorrectable_status_offset, exp);
      hot_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      hot_reset <= 1'b0;
      rd(uncorrectable_status_offset, exp);
      wr(uncorrectable_status_offset, 32'hffff_ffff);
      rd(uncorrectable_status_offset, 32'h0000_0000);
      // Masked detector still sets its status bit
      fire(12'h010);
      rd(uncorrectable_status_offset, 32'h0008_0000);
      chk("unmasked error", {31'h0, unmasked_error}, 32'h0);
      // Detector and clearing write meet at one edge: the set wins
      fork
         fire(12'h008);
         wr(uncorrectable_status_offset, 32'hffff_ffff);
      join
      rd(uncorrectable_status_offset, 32'h0010_0000);
      apb(1'b0, 12'h108, 32'h0000_0000, r, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      chk("unmapped data", r, 32'h0000_0000);
      wr(capability_header_offset, 32'habc0_0000);
      rd(capability_header_offset, 32'habc1_0001);
      wr(header_lock_offset, 32'h0000_0001);
      wr(capability_header_offset, 32'h0000_0000);
      rd(capability_header_offset, 32'habc1_0001);
      // Fundamental reset mid-run clears status, offset and lock
      fire(12'hfff);
      rd(uncorrectable_status_offset, 32'h00ff_3030);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(uncorrectable_status_offset, status_reset);
      exp = {next_offset_reset, capability_version, capability_identifier};
      rd(capability_header_offset, exp);
      print_verdict;
   end
endmodule
